// ---- src/esp_pkg.sv ----
package esp_pkg;
	// Link opcodes
	localparam logic [7:0] OP_ECC_RD  = 8'h18;
	localparam logic [7:0] OP_CFG_RD  = 8'h2b;
	localparam logic [7:0] OP_CFG_PG  = 8'h2f;
	localparam logic [7:0] OP_KEY_RD  = 8'he7;
	localparam logic [7:0] OP_KEY_PG  = 8'he8;
	localparam logic [7:0] OP_LOCK_RD = 8'ha7;
	localparam logic [7:0] OP_LOCK_WR = 8'ha6;

	// Mode configuration word
	localparam logic [15:0] CFG_RESET   = 16'hffff;
	localparam int          SECRET_BIT  = 2;
	localparam int          PERSIST_BIT = 1;
	localparam logic [63:0] KEY_RESET   = 64'hffff_ffff_ffff_ffff;

	// ECC units and status layout
	localparam int          NUM_UNITS    = 16;
	localparam int          UNIT_W       = 4;
	localparam int          UNIT_BYTES   = 16;
	localparam int          ECC_CODE_BIT = 2;
	localparam int          ECC_DATA_BIT = 1;
	localparam int          ECC_OFF_BIT  = 0;
	localparam logic [2:0]  ECC_RESET    = 3'h0;
	localparam logic [4:0]  ECC_RSVD     = 5'h00;

	// Transfer layout: opcode plus the longest field in each direction
	localparam logic [3:0]  LAST_IDX = 4'hf;
	localparam logic [3:0]  CFG_PG_LAST  = 4'h2;
	localparam logic [3:0]  KEY_PG_LAST  = 4'h8;
	localparam logic [3:0]  LOCK_WR_LAST = 4'h1;

	// Link clock made by the host from ref_clk
	localparam int         CLK_PERIOD_NS = 100;
	localparam int         SCK_PERIOD_NS = 1600;
	localparam logic [3:0] SCK_HALF =
		4'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [3:0] SCK_LAST =
		4'(SCK_PERIOD_NS / CLK_PERIOD_NS - 1);

	// Host APB register map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TXLO = 8'h04;
	localparam logic [7:0] A_TXHI = 8'h08;
	localparam logic [7:0] A_RXLO = 8'h0c;
	localparam logic [7:0] A_RXHI = 8'h10;
	localparam logic [7:0] A_STAT = 8'h14;
	localparam logic [7:0] A_INTS = 8'h18;
	localparam logic [7:0] A_INTM = 8'h1c;
	localparam int         INT_DONE = 0;
	localparam int         INT_BUSY = 1;
endpackage

// ---- src/esp_spi_if.sv ----
`timescale 1ns/1ps
interface esp_spi_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	modport host (output sck, output cs_n, output mosi, input miso);
	modport dev (input sck, input cs_n, input mosi, output miso);
endinterface

// ---- src/esp_dev.sv ----
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
// Behaviour
// - ECC read: opcode, unit address, status byte
// - Status kept separately per 16-byte unit
// - Bit 2 flags check code error
// - Bit 1 flags corrected data error
// - Bit 0 flags correction disabled
// - Status bits reset to zero, hardware set
// - No host write path to ECC status
// - Host ignores ECC status bits 7..3
// - 16-bit OTP mode word, read and program
// - Clearing bit 2 selects secret mode
// - Clearing bit 1 selects persistent mode
// - Never both mode bits cleared
// - 64-bit OTP key, erased all ones
// - Lock zero refuses array changes until reset
// - Lock one allows array changes
// - Lock read/write opcodes, bits 7..1 zero
module esp_dev (
	input  wire logic                            ref_clk,
	input  wire logic                            rst_n,
	esp_spi_if.dev                               spi,
	input  wire logic                            hw_reset_n,
	input  wire logic                            ecc_upd_valid,
	input  wire logic [esp_pkg::UNIT_W-1:0]      ecc_upd_unit,
	input  wire logic [2:0]                      ecc_upd_bits,
	input  wire logic                            ppb_change_req,
	output logic                                 array_lock_bit,
	output logic                                 ppb_granted,
	output logic                                 ppb_refused,
	output logic                                 cfg_prog_refused,
	output logic                                 secret_mode_lock_n,
	output logic                                 persistent_mode_lock_n
);
	typedef struct packed {
		logic [2:0]                                 sck_s;
		logic [1:0]                                 cs_s;
		logic [1:0]                                 mosi_s;
		logic [1:0]                                 hwr_s;
		logic [2:0]                                 bitcnt;
		logic [3:0]                                 idx;
		logic [7:0]                                 op;
		logic [7:0]                                 in_sr;
		logic [7:0]                                 out_sr;
		logic [55:0]                                acc;
		logic                                       miso;
		logic [15:0]                                cfg;
		logic [63:0]                                key;
		logic                                       lock;
		logic [esp_pkg::NUM_UNITS-1:0][2:0]         ecc;
		logic                                       granted;
		logic                                       refused;
		logic                                       cfg_refused;
	} esp_dev_state_t;

	esp_dev_state_t r_reg;
	esp_dev_state_t r_next;

	// Byte to send after the byte with index idx has completed
	function automatic logic [7:0] esp_resp(
		input esp_dev_state_t s,
		input logic [7:0]     op,
		input logic [3:0]     idx,
		input logic [7:0]     data
	);
		logic [7:0] v;
		v = 8'h00;
		case (op)
			esp_pkg::OP_ECC_RD:
			begin
				if (idx == 4'h1)
					v = {esp_pkg::ECC_RSVD,
						s.ecc[data[esp_pkg::UNIT_W-1:0]]};
			end
			esp_pkg::OP_CFG_RD:
			begin
				if (idx == 4'h0)
					v = s.cfg[15:8];
				else if (idx == 4'h1)
					v = s.cfg[7:0];
			end
			esp_pkg::OP_KEY_RD:
			begin
				// Hidden key reads as erased, not as an error
				if (idx < 4'h8)
					v = s.cfg[esp_pkg::SECRET_BIT] ?
						s.key[(4'h7 - idx) * 8 +: 8] : 8'hff;
			end
			esp_pkg::OP_LOCK_RD:
			begin
				if (idx == 4'h0)
					v = {7'h00, s.lock};
			end
			default:
				v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb
	begin
		logic [7:0]  byte_in;
		logic [7:0]  cur_op;
		logic [15:0] new_cfg;
		logic        rise;
		logic        fall;
		byte_in = 8'h00;
		cur_op  = 8'h00;
		new_cfg = 16'h0000;
		rise    = r_reg.sck_s[1] & ~r_reg.sck_s[2];
		fall    = ~r_reg.sck_s[1] & r_reg.sck_s[2];
		r_next  = r_reg;
		r_next.sck_s  = {r_reg.sck_s[1:0], spi.sck};
		r_next.cs_s   = {r_reg.cs_s[0], spi.cs_n};
		r_next.mosi_s = {r_reg.mosi_s[0], spi.mosi};
		r_next.hwr_s  = {r_reg.hwr_s[0], hw_reset_n};
		r_next.granted     = 1'b0;
		r_next.refused     = 1'b0;
		r_next.cfg_refused = 1'b0;

		if (r_reg.cs_s[1])
		begin
			r_next.bitcnt = 3'h0;
			r_next.idx    = 4'h0;
			r_next.out_sr = 8'h00;
		end
		else
		begin
			if (rise)
			begin
				byte_in       = {r_reg.in_sr[6:0], r_reg.mosi_s[1]};
				r_next.in_sr  = byte_in;
				r_next.bitcnt = r_reg.bitcnt + 3'h1;
				if (r_reg.bitcnt == 3'h7)
				begin
					cur_op = (r_reg.idx == 4'h0) ? byte_in : r_reg.op;
					r_next.op     = cur_op;
					r_next.out_sr = esp_resp(r_reg, cur_op, r_reg.idx,
						byte_in);
					r_next.acc    = {r_reg.acc[47:0], byte_in};
					if (r_reg.idx != esp_pkg::LAST_IDX)
						r_next.idx = r_reg.idx + 4'h1;
					// Programming acts on the last data byte
					if (cur_op == esp_pkg::OP_CFG_PG &&
						r_reg.idx == esp_pkg::CFG_PG_LAST)
					begin
						// OTP: bits only ever go from one to zero
						new_cfg = r_reg.cfg & {r_reg.acc[7:0], byte_in};
						if (!new_cfg[esp_pkg::SECRET_BIT] &&
							!new_cfg[esp_pkg::PERSIST_BIT])
							r_next.cfg_refused = 1'b1;
						else
							r_next.cfg = new_cfg;
					end
					if (cur_op == esp_pkg::OP_KEY_PG &&
						r_reg.idx == esp_pkg::KEY_PG_LAST &&
						r_reg.cfg[esp_pkg::SECRET_BIT])
						r_next.key = r_reg.key & {r_reg.acc, byte_in};
					if (cur_op == esp_pkg::OP_LOCK_WR &&
						r_reg.idx == esp_pkg::LOCK_WR_LAST &&
						!byte_in[0])
						r_next.lock = 1'b0;
				end
			end
			if (fall)
			begin
				r_next.miso   = r_reg.out_sr[7];
				r_next.out_sr = {r_reg.out_sr[6:0], 1'b0};
			end
		end

		// Hardware reset reloads the lock from the selected mode
		if (!r_reg.hwr_s[1])
		begin
			r_next.lock   = r_reg.cfg[esp_pkg::SECRET_BIT];
			r_next.bitcnt = 3'h0;
			r_next.idx    = 4'h0;
		end

		// Only the correction logic writes unit status
		if (ecc_upd_valid)
			r_next.ecc[ecc_upd_unit] = ecc_upd_bits;

		if (ppb_change_req)
		begin
			if (r_reg.lock)
				r_next.granted = 1'b1;
			else
				r_next.refused = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg       <= '0;
			r_reg.cs_s  <= 2'h3;
			r_reg.hwr_s <= 2'h3;
			r_reg.cfg   <= esp_pkg::CFG_RESET;
			r_reg.key   <= esp_pkg::KEY_RESET;
			r_reg.lock  <= 1'b1;
			r_reg.ecc   <= {esp_pkg::NUM_UNITS{esp_pkg::ECC_RESET}};
		end
		else
			r_reg <= r_next;
	end

	assign spi.miso               = r_reg.miso;
	assign array_lock_bit         = r_reg.lock;
	assign ppb_granted            = r_reg.granted;
	assign ppb_refused            = r_reg.refused;
	assign cfg_prog_refused       = r_reg.cfg_refused;
	assign secret_mode_lock_n     = r_reg.cfg[esp_pkg::SECRET_BIT];
	assign persistent_mode_lock_n = r_reg.cfg[esp_pkg::PERSIST_BIT];
endmodule // esp_dev

// ---- src/esp_host.sv ----
`timescale 1ns/1ps
module esp_host (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	esp_spi_if.host          spi,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);
	typedef enum logic {ESP_IDLE, ESP_RUN} esp_host_st_t;

	typedef struct packed {
		esp_host_st_t st;
		logic [71:0]  tx;
		logic [63:0]  txd;
		logic [63:0]  rx;
		logic [7:0]   bits;
		logic [3:0]   cnt;
		logic         sck;
		logic         cs_n;
		logic         mosi;
		logic [1:0]   miso_s;
		logic [1:0]   int_st;
		logic [1:0]   int_m;
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
		logic         irq;
	} esp_host_state_t;

	esp_host_state_t r_reg;
	esp_host_state_t r_next;

	always_comb
	begin
		logic       wr;
		logic [4:0] nbytes;
		wr     = psel & penable & r_reg.pready & pwrite;
		nbytes = 5'(pwdata[11:8]) + 5'(pwdata[15:12]) + 5'h01;
		r_next = r_reg;
		r_next.miso_s  = {r_reg.miso_s[0], spi.miso};
		r_next.pready  = 1'b0;
		r_next.pslverr = 1'b0;
		r_next.irq     = |(r_reg.int_st & r_reg.int_m);

		if (psel && penable && !r_reg.pready)
		begin
			r_next.pready = 1'b1;
			case (paddr)
				esp_pkg::A_CTRL: r_next.prdata = 32'h0;
				esp_pkg::A_TXLO: r_next.prdata = r_reg.txd[31:0];
				esp_pkg::A_TXHI: r_next.prdata = r_reg.txd[63:32];
				esp_pkg::A_RXLO: r_next.prdata = r_reg.rx[31:0];
				esp_pkg::A_RXHI: r_next.prdata = r_reg.rx[63:32];
				esp_pkg::A_STAT:
					r_next.prdata = {31'h0, r_reg.st == ESP_RUN};
				esp_pkg::A_INTS: r_next.prdata = {30'h0, r_reg.int_st};
				esp_pkg::A_INTM: r_next.prdata = {30'h0, r_reg.int_m};
				default:
				begin
					r_next.prdata  = 32'h0;
					r_next.pslverr = 1'b1;
				end
			endcase
		end

		if (wr)
		begin
			case (paddr)
				esp_pkg::A_CTRL:
				begin
					// A start while busy is dropped and flagged
					if (r_reg.st == ESP_RUN)
						r_next.int_st[esp_pkg::INT_BUSY] = 1'b1;
					else
					begin
						r_next.st   = ESP_RUN;
						r_next.tx   = {pwdata[7:0], r_reg.txd};
						r_next.bits = {nbytes, 3'h0};
						r_next.cnt  = 4'h0;
						r_next.rx   = 64'h0;
						r_next.cs_n = 1'b0;
						r_next.mosi = pwdata[7];
					end
				end
				esp_pkg::A_TXLO: r_next.txd[31:0]  = pwdata;
				esp_pkg::A_TXHI: r_next.txd[63:32] = pwdata;
				esp_pkg::A_INTS:
					r_next.int_st = r_reg.int_st & ~pwdata[1:0];
				esp_pkg::A_INTM: r_next.int_m = pwdata[1:0];
				default: r_next.int_m = r_reg.int_m;
			endcase
		end

		if (r_reg.st == ESP_RUN)
		begin
			r_next.cnt = r_reg.cnt + 4'h1;
			if (r_reg.cnt == esp_pkg::SCK_HALF - 4'h1)
			begin
				// Miso settles within the low half of the link clock
				r_next.sck = 1'b1;
				r_next.rx  = {r_reg.rx[62:0], r_reg.miso_s[1]};
			end
			if (r_reg.cnt == esp_pkg::SCK_LAST)
			begin
				r_next.sck  = 1'b0;
				r_next.cnt  = 4'h0;
				r_next.tx   = {r_reg.tx[70:0], 1'b0};
				r_next.bits = r_reg.bits - 8'h01;
				r_next.mosi = r_reg.tx[70];
				if (r_reg.bits == 8'h01)
				begin
					r_next.st   = ESP_IDLE;
					r_next.cs_n = 1'b1;
					r_next.mosi = 1'b0;
					r_next.int_st[esp_pkg::INT_DONE] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg      <= '0;
			r_reg.st   <= ESP_IDLE;
			r_reg.cs_n <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	assign spi.sck  = r_reg.sck;
	assign spi.cs_n = r_reg.cs_n;
	assign spi.mosi = r_reg.mosi;
	assign prdata   = r_reg.prdata;
	assign pready   = r_reg.pready;
	assign pslverr  = r_reg.pslverr;
	assign irq      = r_reg.irq;
endmodule // esp_host

// ---- testbench/esp_monitor.sv ----
`timescale 1ns/1ps
module esp_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic hw_reset_n,
	input wire logic ppb_change_req,
	input wire logic array_lock_bit,
	input wire logic ppb_granted,
	input wire logic ppb_refused,
	input wire logic secret_mode_lock_n,
	input wire logic persistent_mode_lock_n
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	sequence hw_held;
		!hw_reset_n [*4];
	endsequence
	sequence bit_high;
		sck [*8] ##1 !sck;
	endsequence
	a_sck_idle: assert property (cs_n |-> !sck)
		else $error("link clock moved outside a frame");
	a_sck_high_span: assert property ($rose(sck) |-> bit_high)
		else $error("link clock high phase not 8 cycles");
	a_sck_low_span: assert property ($fell(sck) |-> !sck [*8])
		else $error("link clock low phase too short");
	a_mosi_steady: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("host data changed while clock high");
	a_lock_grant: assert property (
		ppb_change_req && array_lock_bit |=> ppb_granted && !ppb_refused)
		else $error("array change not granted while unlocked");
	a_lock_refuse: assert property (
		ppb_change_req && !array_lock_bit |=> ppb_refused && !ppb_granted)
		else $error("array change not refused while locked");
	// Only a hardware reset may reopen the array
	a_lock_rise_cause: assert property ($rose(array_lock_bit) |->
		!$past(hw_reset_n, 2) || !$past(hw_reset_n, 3) ||
		!$past(hw_reset_n, 4) || !$past(hw_reset_n, 5))
		else $error("lock reopened without reset");
	a_modes_exclusive: assert property (
		secret_mode_lock_n || persistent_mode_lock_n)
		else $error("both protection modes selected");
	a_hw_lock_load: assert property (
		hw_held |-> array_lock_bit == secret_mode_lock_n)
		else $error("lock not reloaded from mode on reset");
endmodule // esp_monitor

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hw_reset_n = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        upd_v = 1'b0;
	logic [3:0]  upd_u = 4'h0;
	logic [2:0]  upd_b = 3'h0;
	logic        req = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, lock, ok, no, cfg_no, sec_n, per_n;
	int          num_errors = 0;
	int          n_compared = 0;
	int          n_ok = 0, n_no = 0, n_cfg = 0;
	esp_spi_if spi_bus ();
	esp_host esp_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .spi(spi_bus.host),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq));
	esp_dev esp_dev_inst (.ref_clk(ref_clk), .rst_n(rst_n), .spi(spi_bus.dev),
		.hw_reset_n(hw_reset_n), .ecc_upd_valid(upd_v), .ecc_upd_unit(upd_u),
		.ecc_upd_bits(upd_b), .ppb_change_req(req), .array_lock_bit(lock),
		.ppb_granted(ok), .ppb_refused(no), .cfg_prog_refused(cfg_no),
		.secret_mode_lock_n(sec_n), .persistent_mode_lock_n(per_n));
	esp_monitor esp_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.sck(spi_bus.sck), .cs_n(spi_bus.cs_n), .mosi(spi_bus.mosi),
		.hw_reset_n(hw_reset_n), .ppb_change_req(req), .array_lock_bit(lock),
		.ppb_granted(ok), .ppb_refused(no), .secret_mode_lock_n(sec_n),
		.persistent_mode_lock_n(per_n));
	always #50 ref_clk = ~ref_clk;
	// Pulses are counted so no task can miss one
	always @(posedge ref_clk)
	begin
		if (ok === 1'b1) n_ok++;
		if (no === 1'b1) n_no++;
		if (cfg_no === 1'b1) n_cfg++;
	end
	task automatic chk(input string nm, input logic [63:0] s, x);
		n_compared++;
		if (s !== x)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// No wait count assumed; a hung slave is left to the watchdog
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] op, input logic [3:0] ntx, nrx,
		input logic [63:0] tx, output logic [63:0] rx);
		logic [31:0] h, l;
		logic        e;
		int          n = 0;
		apb(1'b1, esp_pkg::A_TXHI, tx[63:32], h, e);
		apb(1'b1, esp_pkg::A_TXLO, tx[31:0], h, e);
		apb(1'b1, esp_pkg::A_CTRL, {16'h0, nrx, ntx, op}, h, e);
		while (irq !== 1'b1 && n < 3000)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk("irq", 64'(irq), 64'h1);
		apb(1'b0, esp_pkg::A_RXHI, 32'h0, h, e);
		apb(1'b0, esp_pkg::A_RXLO, 32'h0, l, e);
		apb(1'b1, esp_pkg::A_INTS, 32'h1, rx[31:0], e);
		rx = {h, l};
	endtask
	task automatic persistent_sector_bit(input logic grant);
		int a = n_ok;
		int b = n_no;
		@(posedge ref_clk);
		req <= 1'b1;
		@(posedge ref_clk);
		req <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("granted", 64'(n_ok - a), 64'(grant));
		chk("refused", 64'(n_no - b), 64'(!grant));
	endtask
	task automatic hw_rst;
		@(posedge ref_clk);
		hw_reset_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		hw_reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic t_irq;
		logic [31:0] q;
		logic        e;
		int          n = 0;
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk("slverr", 64'(e), 64'h1);
		chk("unmapped", 64'(q), 64'h0);
		apb(1'b1, esp_pkg::A_CTRL, {24'h000010, esp_pkg::OP_LOCK_RD}, q, e);
		apb(1'b1, esp_pkg::A_CTRL, {24'h000010, esp_pkg::OP_LOCK_RD}, q, e);
		do
			apb(1'b0, esp_pkg::A_STAT, 32'h0, q, e);
		while (q[0] === 1'b1 && ++n < 200);
		chk("frame idle", 64'(q[0]), 64'h0);
		chk("masked irq", 64'(irq), 64'h0);
		apb(1'b0, esp_pkg::A_INTS, 32'h0, q, e);
		chk("int status", 64'(q[1:0]), 64'h3);
		apb(1'b1, esp_pkg::A_INTM, 32'h1, q, e);
		repeat (2) @(posedge ref_clk);
		chk("unmasked irq", 64'(irq), 64'h1);
		apb(1'b1, esp_pkg::A_INTS, 32'h3, q, e);
		repeat (2) @(posedge ref_clk);
		chk("cleared irq", 64'(irq), 64'h0);
	endtask
	task automatic t_ecc;
		logic [63:0] r;
		logic [2:0]  pat [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
		for (int i = 0; i < 3; i++)
		begin
			@(posedge ref_clk);
			upd_v <= 1'b1;
			upd_u <= 4'(i * 7);
			upd_b <= pat[i];
			@(posedge ref_clk);
			upd_v <= 1'b0;
		end
		// Unit byte 21 reaches unit 5, never updated
		for (int i = 0; i < 4; i++)
		begin
			xfer(esp_pkg::OP_ECC_RD, 4'h1, 4'h1, {8'(i * 7), 56'h0}, r);
			chk("ecc status", 64'(r[2:0]), 64'(pat[i]));
		end
	endtask
	task automatic rd(input logic [7:0] op, input logic [3:0] n,
		input logic [63:0] x);
		logic [63:0] r;
		xfer(op, 4'h0, n, 64'h0, r);
		// Opcode byte shifts in stale link data, so only read bytes count
		chk("readback", r & ~({64{1'b1}} << (8 * n)), x);
	endtask
	task automatic t_fresh;
		logic [63:0] r;
		rd(esp_pkg::OP_CFG_RD, 4'h2, 64'(esp_pkg::CFG_RESET));
		rd(esp_pkg::OP_KEY_RD, 4'h8, esp_pkg::KEY_RESET);
		rd(esp_pkg::OP_LOCK_RD, 4'h1, 64'h1);
		persistent_sector_bit(1'b1);
		xfer(esp_pkg::OP_CFG_PG, 4'h2, 4'h0, {16'hfff9, 48'h0}, r);
		chk("both refused", 64'(n_cfg), 64'h1);
		rd(esp_pkg::OP_CFG_RD, 4'h2, 64'hffff);
		xfer(esp_pkg::OP_CFG_PG, 4'h2, 4'h0, {16'hfffd, 48'h0}, r);
		rd(esp_pkg::OP_CFG_RD, 4'h2, 64'hfffd);
		chk("persist mode", 64'({sec_n, per_n}), 64'h2);
		xfer(esp_pkg::OP_KEY_PG, 4'h8, 4'h0, 64'h0123_4567_89ab_cdef, r);
		rd(esp_pkg::OP_KEY_RD, 4'h8, 64'h0123_4567_89ab_cdef);
		xfer(esp_pkg::OP_LOCK_WR, 4'h1, 4'h0, {8'hfe, 56'h0}, r);
		rd(esp_pkg::OP_LOCK_RD, 4'h1, 64'h0);
		persistent_sector_bit(1'b0);
		xfer(esp_pkg::OP_LOCK_WR, 4'h1, 4'h0, {8'hff, 56'h0}, r);
		rd(esp_pkg::OP_LOCK_RD, 4'h1, 64'h0);
		hw_rst;
		rd(esp_pkg::OP_LOCK_RD, 4'h1, 64'h1);
		persistent_sector_bit(1'b1);
	endtask
	task automatic t_secret;
		logic [63:0] r;
		logic [31:0] q;
		logic        e;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(1'b1, esp_pkg::A_INTM, 32'h1, q, e);
		rd(esp_pkg::OP_CFG_RD, 4'h2, 64'hffff);
		xfer(esp_pkg::OP_KEY_PG, 4'h8, 4'h0, 64'h0123_4567_89ab_cdef, r);
		xfer(esp_pkg::OP_CFG_PG, 4'h2, 4'h0, {16'hfffb, 48'h0}, r);
		rd(esp_pkg::OP_CFG_RD, 4'h2, 64'hfffb);
		chk("secret mode", 64'({sec_n, per_n}), 64'h1);
		rd(esp_pkg::OP_KEY_RD, 4'h8, esp_pkg::KEY_RESET);
		hw_rst;
		rd(esp_pkg::OP_LOCK_RD, 4'h1, 64'h0);
		persistent_sector_bit(1'b0);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_irq;
		t_ecc;
		t_fresh;
		t_secret;
		close_out;
	end
	// Whole run needs about 13000 cycles
	initial
	begin
		#6000000;
		num_errors++;
		close_out;
	end
endmodule // tb
